/* File: logic/bmr_block_ram.sv */
// dual-port embedded block memory with wishbone configuration registers
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module bmr_block_ram (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire bmr_pkg::bmr_req_t port_a_req_i,
  input wire bmr_pkg::bmr_req_t port_b_req_i,
  input wire logic port_a_output_clear_i,
  input wire logic port_b_output_clear_i,
  input wire logic global_clear_low_i,
  output logic [35:0] port_a_rdata_o,
  output logic [35:0] port_b_rdata_o
);

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    bmr_pkg::bmr_cfg_t cfg;
    logic [7:0] init_addr;
    logic [31:0] init_lo;
    bmr_pkg::bmr_req_t [1:0] req;
  } bmr_state_t;

  localparam bmr_state_t ST_RESET = '{
    ack: 1'b0,
    dat: 32'h0000_0000,
    cfg: bmr_pkg::CFG_RESET,
    init_addr: bmr_pkg::INIT_ADDR_RESET,
    init_lo: 32'h0000_0000,
    req: '0
  };

  bmr_state_t st_reg;
  bmr_state_t st_next;
  logic [35:0] mem [0:bmr_pkg::WORDS-1];
  bmr_pkg::bmr_req_t req_in [2];
  logic [1:0] clr_local;
  logic [1:0] clr_any;
  logic [1:0] in_range;
  logic [1:0] wr;
  logic [1:0] rd_go;
  logic [5:0] width [2];
  logic [7:0] word [2];
  logic [5:0] lane [2];
  logic [35:0] lane_mask [2];
  logic [35:0] rd [2];
  logic [35:0] wd_port [2];
  logic [35:0] wd_shift [2];
  logic [35:0] merged [2];
  logic [35:0] rdata [2];
  logic cfg_err;
  logic bus_req;
  logic init_commit;

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge_bytes[8*i +: 8] = sel[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
  endfunction : merge_bytes

  // port bundles and clear sources
  assign req_in[0] = port_a_req_i;
  assign req_in[1] = port_b_req_i;
  assign clr_local = {port_b_output_clear_i, port_a_output_clear_i};
  assign clr_any = clr_local | {2{!global_clear_low_i}};
  assign cfg_err = (st_reg.cfg.mode == bmr_pkg::BMR_TRUE_DUAL) &&
                   (st_reg.cfg.a_width == bmr_pkg::BMR_X36 ||
                    st_reg.cfg.b_width == bmr_pkg::BMR_X36);

  // per-port width, bit mapping, array read and output stage
  for (genvar p = 0; p < 2; p++) begin : g_port
    bmr_pkg::bmr_width_t code;
    logic [18:0] bit_ofs;
    assign code = (p == 0) ? st_reg.cfg.a_width : st_reg.cfg.b_width;
    assign width[p] = (st_reg.cfg.mode == bmr_pkg::BMR_TRUE_DUAL && code == bmr_pkg::BMR_X36) ?
                      bmr_pkg::bmr_width_bits(bmr_pkg::BMR_X18) :
                      bmr_pkg::bmr_width_bits(code);
    assign bit_ofs = 19'(st_reg.req[p].addr) * 19'(width[p]);
    assign in_range[p] = bit_ofs < 19'(bmr_pkg::ARRAY_BITS);
    assign word[p] = 8'(bit_ofs / 19'(bmr_pkg::WORD_BITS));
    assign lane[p] = 6'(bit_ofs % 19'(bmr_pkg::WORD_BITS));
    assign lane_mask[p] = ((36'h1 << width[p]) - 36'h1) << lane[p];
    assign rd[p] = in_range[p] ? ((mem[word[p]] & lane_mask[p]) >> lane[p]) : '0;
    assign wd_port[p] = st_reg.req[p].wdata & ((36'h1 << width[p]) - 36'h1);
    assign wd_shift[p] = wd_port[p] << lane[p];
    assign wr[p] = st_reg.req[p].en && st_reg.req[p].we && in_range[p];
    assign rd_go[p] = st_reg.req[p].en && !st_reg.req[p].we && in_range[p] && !clr_any[p];

    bmr_port_out #(
      .DATA_W(bmr_pkg::DATA_W)
    ) u_out (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .cycle_i(st_reg.req[p].en && in_range[p]),
      .we_i(st_reg.req[p].we),
      .wmode_i((p == 0) ? st_reg.cfg.a_wmode : st_reg.cfg.b_wmode),
      .wdata_i(wd_port[p]),
      .rdata_i(rd[p]),
      .clear_i(clr_any[p]),
      .async_i((p == 0) ? st_reg.cfg.a_async : st_reg.cfg.b_async),
      .outreg_i((p == 0) ? st_reg.cfg.a_outreg : st_reg.cfg.b_outreg),
      .rdata_o(rdata[p])
    );
  end

  // write merging; port b wins bits both ports write in one cycle
  always_comb begin
    merged[0] = (mem[word[0]] & ~lane_mask[0]) | (wd_shift[0] & lane_mask[0]);
    merged[1] = (((wr[0] && word[0] == word[1]) ? merged[0] : mem[word[1]]) & ~lane_mask[1]) |
                (wd_shift[1] & lane_mask[1]);
  end

  // storage array: bus preload or captured port writes, never the clears
  always_ff @(posedge core_clk_i) begin
    if (init_commit) begin
      mem[st_reg.init_addr] <= {wb_dat_i[bmr_pkg::INIT_HI_BITS-1:0], st_reg.init_lo};
    end else begin
      if (wr[0]) begin
        mem[word[0]] <= merged[0];
      end
      if (wr[1]) begin
        mem[word[1]] <= merged[1];
      end
    end
  end

  // bus decode
  assign bus_req = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign init_commit = bus_req && wb_we_i && wb_adr_i == bmr_pkg::INIT_HI_OFS &&
                       wb_sel_i[0] && !st_reg.cfg.run;

  // next state: registers, ack and request capture
  always_comb begin
    bmr_pkg::bmr_req_t r;
    logic [31:0] cfg_word;
    logic [31:0] cfg_new;
    r = '0;
    cfg_word = 32'(st_reg.cfg);
    cfg_new = merge_bytes(cfg_word, wb_dat_i, wb_sel_i);
    st_next = st_reg;
    st_next.ack = bus_req;
    st_next.dat = 32'h0000_0000;
    if (bus_req && wb_we_i) begin
      case (wb_adr_i)
        bmr_pkg::CFG_OFS: begin
          st_next.cfg = bmr_pkg::bmr_cfg_t'(cfg_new[bmr_pkg::CFG_BITS-1:0]);
        end
        bmr_pkg::INIT_ADDR_OFS: begin
          if (wb_sel_i[0]) begin
            st_next.init_addr = wb_dat_i[7:0];
          end
        end
        bmr_pkg::INIT_LO_OFS: begin
          st_next.init_lo = merge_bytes(st_reg.init_lo, wb_dat_i, wb_sel_i);
        end
        bmr_pkg::INIT_HI_OFS: begin
          if (init_commit) begin
            st_next.init_addr = st_reg.init_addr + 8'h01;
          end
        end
        default: st_next.dat = 32'h0000_0000; // unmapped or read-only: ignored
      endcase
    end else if (bus_req) begin
      case (wb_adr_i)
        bmr_pkg::CFG_OFS: st_next.dat = cfg_word;
        bmr_pkg::STATUS_OFS: begin
          st_next.dat[bmr_pkg::STAT_ERR_BIT] = cfg_err;
          st_next.dat[bmr_pkg::STAT_RUN_BIT] = st_reg.cfg.run;
        end
        bmr_pkg::INIT_ADDR_OFS: st_next.dat = {24'h00_0000, st_reg.init_addr};
        bmr_pkg::INIT_LO_OFS: st_next.dat = st_reg.init_lo;
        default: st_next.dat = 32'h0000_0000;
      endcase
    end
    // capture requests at the array input, shaped by the memory mode
    for (int p = 0; p < 2; p++) begin
      r = req_in[p];
      if (!st_reg.cfg.run) begin
        r = '0;
      end
      unique case (st_reg.cfg.mode)
        bmr_pkg::BMR_SINGLE: begin
          if (p == 1) begin
            r = '0;
          end
        end
        bmr_pkg::BMR_TRUE_DUAL: r.en = r.en;
        bmr_pkg::BMR_PSEUDO_DUAL: begin
          if (p == 0) begin
            r.en = r.en && r.we;
          end else begin
            r.we = 1'b0;
          end
        end
        default: r = '0; // mode code 3 disables both ports
      endcase
      st_next.req[p] = r;
    end
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.dat;
  assign port_a_rdata_o = rdata[0];
  assign port_b_rdata_o = rdata[1];

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_ACK_SINGLE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("wishbone ack held longer than one cycle");

  AST_CAPTURE: assert property (
    port_b_req_i.en && st_reg.cfg.run && st_reg.cfg.mode == bmr_pkg::BMR_TRUE_DUAL
    |=> st_reg.req[1].en && st_reg.req[1].addr == $past(port_b_req_i.addr) &&
        st_reg.req[1].wdata == $past(port_b_req_i.wdata))
    else $error("port b request not captured at the array input");

  AST_READ_LATENCY: assert property (
    rd_go[0] && !st_reg.cfg.a_outreg ##1 !clr_any[0] && !st_reg.cfg.a_outreg
    |-> port_a_rdata_o == $past(rd[0]))
    else $error("unregistered read data late or wrong");

  AST_READ_REG_LATENCY: assert property (
    rd_go[0] && st_reg.cfg.a_outreg ##1 !clr_any[0] && st_reg.cfg.a_outreg
    |=> port_a_rdata_o == $past(rd[0], 2))
    else $error("registered read data not two clocks after capture");

  AST_ASYNC_CLEAR: assert property (
    st_reg.cfg.b_async && port_b_output_clear_i |-> port_b_rdata_o == '0)
    else $error("asynchronous clear did not zero port b at once");

  AST_LOCAL_CLEAR: assert property (
    port_a_output_clear_i && global_clear_low_i |=> port_a_rdata_o == '0)
    else $error("local clear did not zero port a");

  AST_GLOBAL_CLEAR: assert property (
    !global_clear_low_i |=> port_a_rdata_o == '0 && port_b_rdata_o == '0)
    else $error("global clear did not zero both ports");

  AST_DUAL_WIDTH_CAP: assert property (
    st_reg.cfg.mode == bmr_pkg::BMR_TRUE_DUAL
    |-> width[0] <= 6'h12 && width[1] <= 6'h12 &&
        cfg_err == (st_reg.cfg.a_width == bmr_pkg::BMR_X36 ||
                    st_reg.cfg.b_width == bmr_pkg::BMR_X36))
    else $error("true dual port exceeded x18");

  AST_READ_LATENCY_B: assert property (
    rd_go[1] && !st_reg.cfg.b_outreg ##1 !clr_any[1] && !st_reg.cfg.b_outreg
    |-> port_b_rdata_o == $past(rd[1]))
    else $error("port b unregistered read data late or wrong");

  AST_LOCAL_CLEAR_OWN: assert property (
    port_a_output_clear_i && !clr_any[1] && !st_reg.req[1].en && !st_reg.cfg.b_outreg
    ##1 !clr_any[1] && !st_reg.cfg.b_outreg
    |-> port_b_rdata_o == $past(port_b_rdata_o))
    else $error("port a clear disturbed the port b output");

  AST_WB_IDLE_DATA: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("wishbone read data not zero outside ack");

  AST_PRELOAD_STEP: assert property (
    init_commit |=> st_reg.init_addr == $past(st_reg.init_addr) + 8'h01)
    else $error("preload address did not step after a commit");

  AST_SINGLE_B_OFF: assert property (
    st_reg.cfg.mode == bmr_pkg::BMR_SINGLE |=> !st_reg.req[1].en)
    else $error("port b captured a request in single port mode");

  COV_READ_A: cover property (rd_go[0] ##1 port_a_rdata_o != '0);
  COV_WRITE_B: cover property (wr[1] && st_reg.cfg.b_wmode == bmr_pkg::BMR_WRITE_THROUGH);
  COV_GLOBAL: cover property (!global_clear_low_i ##1 global_clear_low_i);
  COV_PRELOAD: cover property (init_commit ##[1:20] st_reg.cfg.run);

endmodule : bmr_block_ram

`default_nettype wire

/* File: logic/bmr_pkg.sv */
// shared constants and types for the dual-port embedded block memory
package bmr_pkg;

  // storage geometry
  localparam int unsigned ARRAY_BITS = 9216;
  localparam int unsigned WORD_BITS = 36;
  localparam int unsigned WORDS = 256;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 36;

  // register byte offsets on the wishbone side
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INIT_ADDR_OFS = 8'h08;
  localparam logic [7:0] INIT_LO_OFS = 8'h0C;
  localparam logic [7:0] INIT_HI_OFS = 8'h10;

  // field positions and sizes
  localparam int unsigned CFG_BITS = 17;
  localparam int unsigned INIT_HI_BITS = 4;
  localparam int unsigned STAT_ERR_BIT = 0;
  localparam int unsigned STAT_RUN_BIT = 1;

  // memory organisation
  typedef enum logic [1:0] {
    BMR_SINGLE = 2'h0,
    BMR_TRUE_DUAL = 2'h1,
    BMR_PSEUDO_DUAL = 2'h2
  } bmr_mode_t;

  // port data width codes
  typedef enum logic [2:0] {
    BMR_X1 = 3'h0,
    BMR_X2 = 3'h1,
    BMR_X4 = 3'h2,
    BMR_X9 = 3'h3,
    BMR_X18 = 3'h4,
    BMR_X36 = 3'h5
  } bmr_width_t;

  // what a port output shows during its own write cycle
  typedef enum logic [1:0] {
    BMR_NORMAL = 2'h0,
    BMR_WRITE_THROUGH = 2'h1,
    BMR_READ_BEFORE_WRITE = 2'h2
  } bmr_wmode_t;

  // configuration register layout, bit 0 upward: mode .. run
  typedef struct packed {
    logic run;
    logic b_async;
    logic a_async;
    logic b_outreg;
    logic a_outreg;
    bmr_wmode_t b_wmode;
    bmr_wmode_t a_wmode;
    bmr_width_t b_width;
    bmr_width_t a_width;
    bmr_mode_t mode;
  } bmr_cfg_t;

  localparam bmr_cfg_t CFG_RESET = '0;
  localparam logic [7:0] INIT_ADDR_RESET = 8'h00;

  // one port request from fabric logic
  typedef struct packed {
    logic en;
    logic we;
    logic [12:0] addr;
    logic [35:0] wdata;
  } bmr_req_t;

  // width code to number of data bits
  function automatic logic [5:0] bmr_width_bits(input bmr_width_t code);
    unique case (code)
      BMR_X1: bmr_width_bits = 6'h01;
      BMR_X2: bmr_width_bits = 6'h02;
      BMR_X4: bmr_width_bits = 6'h04;
      BMR_X9: bmr_width_bits = 6'h09;
      BMR_X18: bmr_width_bits = 6'h12;
      BMR_X36: bmr_width_bits = 6'h24;
      default: bmr_width_bits = 6'h01; // codes 6 and 7 act as x1
    endcase
  endfunction : bmr_width_bits

endpackage : bmr_pkg

/* File: logic/bmr_port_out.sv */
// output latch, optional output register and clears of one memory port
`timescale 1ns/1ps
`default_nettype none

module bmr_port_out #(
  parameter int unsigned DATA_W = 36
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic cycle_i,
  input wire logic we_i,
  input wire bmr_pkg::bmr_wmode_t wmode_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic [DATA_W-1:0] rdata_i,
  input wire logic clear_i,
  input wire logic async_i,
  input wire logic outreg_i,
  output logic [DATA_W-1:0] rdata_o
);

  typedef struct packed {
    logic [DATA_W-1:0] latch;
    logic [DATA_W-1:0] oreg;
  } bmr_out_state_t;

  bmr_out_state_t st_reg;
  bmr_out_state_t st_next;

  // latch update per write behaviour, clear has priority
  always_comb begin
    st_next = st_reg;
    st_next.oreg = st_reg.latch;
    if (cycle_i) begin
      if (!we_i) begin
        st_next.latch = rdata_i;
      end else begin
        unique case (wmode_i)
          bmr_pkg::BMR_NORMAL: st_next.latch = st_reg.latch;
          bmr_pkg::BMR_WRITE_THROUGH: st_next.latch = wdata_i;
          bmr_pkg::BMR_READ_BEFORE_WRITE: st_next.latch = rdata_i;
          default: st_next.latch = st_reg.latch; // code 3 behaves as normal
        endcase
      end
    end
    if (clear_i) begin
      st_next.latch = '0;
      st_next.oreg = '0;
    end
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // async clear masks at once; otherwise latch or output register
  assign rdata_o = (async_i && clear_i) ? '0 : (outreg_i ? st_reg.oreg : st_reg.latch);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_NORMAL_HOLDS: assert property (
    cycle_i && we_i && wmode_i == bmr_pkg::BMR_NORMAL && !clear_i
    |=> st_reg.latch == $past(st_reg.latch))
    else $error("normal write changed the port output latch");

  AST_WRITE_THROUGH: assert property (
    cycle_i && we_i && wmode_i == bmr_pkg::BMR_WRITE_THROUGH && !clear_i
    |=> st_reg.latch == $past(wdata_i))
    else $error("write-through did not show the written data");

  AST_READ_BEFORE_WRITE: assert property (
    cycle_i && we_i && wmode_i == bmr_pkg::BMR_READ_BEFORE_WRITE && !clear_i
    |=> st_reg.latch == $past(rdata_i))
    else $error("read-before-write did not show the old contents");

endmodule : bmr_port_out

`default_nettype wire

/* File: bench/bmr_fabric_model.sv */
// fabric logic model that drives both memory ports
`timescale 1ns/1ps
`default_nettype none

module bmr_fabric_model (
  input wire logic rom_mode_i,
  input wire bmr_pkg::bmr_req_t cmd_a_i,
  input wire bmr_pkg::bmr_req_t cmd_b_i,
  output var bmr_pkg::bmr_req_t port_a_req_o,
  output var bmr_pkg::bmr_req_t port_b_req_o
);
  // idle ports show toggled address and data so stale values are never reused
  always_comb begin
    port_a_req_o = cmd_a_i;
    port_b_req_o = cmd_b_i;
    port_a_req_o.we = cmd_a_i.we & ~rom_mode_i;
    port_b_req_o.we = cmd_b_i.we & ~rom_mode_i;
    if (!cmd_a_i.en) begin
      port_a_req_o.addr = ~cmd_a_i.addr;
      port_a_req_o.wdata = ~cmd_a_i.wdata;
    end
    if (!cmd_b_i.en) begin
      port_b_req_o.addr = ~cmd_b_i.addr;
      port_b_req_o.wdata = ~cmd_b_i.wdata;
    end
  end
endmodule : bmr_fabric_model

`default_nettype wire

/* File: bench/bmr_block_ram_tb_top.sv */
// self-checking bench for the dual-port block memory
`timescale 1ns/1ps
`default_nettype none

module bmr_block_ram_tb_top;
  logic clk, rst_n, cyc, stb, wwe, ack, clr_a, clr_b, gclr_n, rom;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, rv;
  logic [3:0] sel;
  logic [35:0] rd_a, rd_b, nv, ex, eb;
  logic [35:0] mem [4];
  bmr_pkg::bmr_req_t cmd_a, cmd_b, req_a, req_b;
  bmr_pkg::bmr_cfg_t cfg;
  int err_total, cmp_count, i;

  bmr_block_ram dut (.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wwe), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .port_a_req_i(req_a), .port_b_req_i(req_b),
    .port_a_output_clear_i(clr_a), .port_b_output_clear_i(clr_b),
    .global_clear_low_i(gclr_n), .port_a_rdata_o(rd_a), .port_b_rdata_o(rd_b));

  bmr_fabric_model fab (.rom_mode_i(rom), .cmd_a_i(cmd_a), .cmd_b_i(cmd_b),
    .port_a_req_o(req_a), .port_b_req_o(req_b));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run
  task automatic stop_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    stop_test();
  end

  // compare and report
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    check({4'h0, rv}, {4'h0, e});
  endtask : rdc

  task automatic setcfg();
    wb(1'b1, bmr_pkg::CFG_OFS, {15'h0, cfg});
  endtask : setcfg

  // one port request; checks the output lat cycles after capture
  task automatic pop(input logic b, input logic w, input logic [12:0] a, input logic [35:0] d,
                     input int lat, input logic [35:0] old, input logic [35:0] exp);
    bmr_pkg::bmr_req_t r;
    r = {1'b1, w, a, d};
    @(posedge clk);
    if (b) cmd_b <= r;
    else cmd_a <= r;
    @(posedge clk);
    if (b) cmd_b.en <= 1'b0;
    else cmd_a.en <= 1'b0;
    for (int k = 1; k <= lat; k++) begin
      @(posedge clk);
      #1;
      check(b ? rd_b : rd_a, (k < lat) ? old : exp);
    end
  endtask : pop

  // main sequence
  initial begin
    rst_n = 1'b0;
    {cyc, stb, wwe, clr_a, clr_b, rom} = '0;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'hF;
    gclr_n = 1'b1;
    cmd_a = '0;
    cmd_b = '0;
    err_total = 0;
    cmp_count = 0;
    cfg = bmr_pkg::CFG_RESET;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc(bmr_pkg::CFG_OFS, 32'h0);
    rdc(bmr_pkg::STATUS_OFS, 32'h0);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rdc(8'h40, 32'h0);
    rdc(bmr_pkg::CFG_OFS, 32'h0);
    // preload four words before the ports run
    wb(1'b1, bmr_pkg::INIT_ADDR_OFS, 32'h0);
    for (i = 0; i < 4; i++) begin
      mem[i] = 36'h9_A5C3_1E70 + 36'h7_1234_5687 * 36'(i);
      wb(1'b1, bmr_pkg::INIT_LO_OFS, mem[i][31:0]);
      wb(1'b1, bmr_pkg::INIT_HI_OFS, {28'h0, mem[i][35:32]});
    end
    rdc(bmr_pkg::INIT_ADDR_OFS, 32'h4);
    cfg.a_width = bmr_pkg::BMR_X36;
    cfg.run = 1'b1;
    setcfg();
    rdc(bmr_pkg::STATUS_OFS, 32'h2);
    for (i = 0; i < 4; i++) pop(1'b0, 1'b0, 13'(i), 36'h0, 1, 36'h0, mem[i]);
    // three write behaviours on port a
    for (i = 0; i < 3; i++) begin
      cfg.a_wmode = bmr_pkg::bmr_wmode_t'(i);
      setcfg();
      pop(1'b0, 1'b0, 13'h0, 36'h0, 1, 36'h0, mem[0]);
      nv = mem[1] ^ {9{4'(i + 3)}};
      ex = (i == 0) ? mem[0] : (i == 1) ? nv : mem[1];
      pop(1'b0, 1'b1, 13'h1, nv, 1, 36'h0, ex);
      mem[1] = nv;
    end
    cfg.a_outreg = 1'b1;
    setcfg();
    pop(1'b0, 1'b0, 13'h1, 36'h0, 2, ex, mem[1]);
    // narrow widths follow the linear bit order
    cfg.a_outreg = 1'b0;
    cfg.a_width = bmr_pkg::BMR_X9;
    setcfg();
    for (i = 0; i < 4; i++) pop(1'b0, 1'b0, 13'(i), 36'h0, 1, 36'h0, {27'h0, mem[0][9*i +: 9]});
    cfg.a_width = bmr_pkg::BMR_X1;
    setcfg();
    pop(1'b0, 1'b0, 13'h25, 36'h0, 1, 36'h0, {35'h0, mem[1][1]});
    // true dual port with mixed widths
    cfg.mode = bmr_pkg::BMR_TRUE_DUAL;
    cfg.a_width = bmr_pkg::BMR_X18;
    cfg.b_width = bmr_pkg::BMR_X9;
    setcfg();
    pop(1'b1, 1'b0, 13'h5, 36'h0, 1, 36'h0, {27'h0, mem[1][17:9]});
    pop(1'b0, 1'b0, 13'h1, 36'h0, 1, 36'h0, {18'h0, mem[0][35:18]});
    cfg.a_width = bmr_pkg::BMR_X36;
    setcfg();
    rdc(bmr_pkg::STATUS_OFS, 32'h3);
    pop(1'b0, 1'b0, 13'h3, 36'h0, 1, 36'h0, {18'h0, mem[1][35:18]});
    // output clears: local sync, local async, global
    cfg.a_width = bmr_pkg::BMR_X18;
    cfg.b_async = 1'b1;
    setcfg();
    eb = {27'h0, mem[1][17:9]};
    @(posedge clk);
    clr_a <= 1'b1;
    @(posedge clk);
    clr_a <= 1'b0;
    #1;
    check(rd_a, 36'h0);
    check(rd_b, eb);
    @(posedge clk);
    clr_b <= 1'b1;
    #1;
    check(rd_b, 36'h0);
    @(posedge clk);
    clr_b <= 1'b0;
    pop(1'b0, 1'b0, 13'h1, 36'h0, 1, 36'h0, {18'h0, mem[0][35:18]});
    pop(1'b1, 1'b0, 13'h5, 36'h0, 1, 36'h0, eb);
    @(posedge clk);
    gclr_n <= 1'b0;
    @(posedge clk);
    gclr_n <= 1'b1;
    #1;
    check(rd_a, 36'h0);
    check(rd_b, 36'h0);
    // x4 and x2 ports; port b writes through its output register
    cfg.a_width = bmr_pkg::BMR_X4;
    cfg.b_width = bmr_pkg::BMR_X2;
    cfg.b_wmode = bmr_pkg::BMR_WRITE_THROUGH;
    cfg.b_outreg = 1'b1;
    setcfg();
    pop(1'b0, 1'b0, 13'hA, 36'h0, 1, 36'h0, {32'h0, mem[1][7:4]});
    mem[0][3:2] = ~mem[0][3:2];
    pop(1'b1, 1'b1, 13'h1, {34'h0, mem[0][3:2]}, 2, 36'h0, {34'h0, mem[0][3:2]});
    pop(1'b0, 1'b0, 13'h0, 36'h0, 1, 36'h0, {32'h0, mem[0][3:0]});
    // pseudo dual port, first as rom with writes held off
    cfg.mode = bmr_pkg::BMR_PSEUDO_DUAL;
    cfg.b_outreg = 1'b0;
    cfg.a_width = bmr_pkg::BMR_X36;
    cfg.b_width = bmr_pkg::BMR_X36;
    setcfg();
    @(posedge clk);
    rom <= 1'b1;
    pop(1'b0, 1'b1, 13'h0, ~mem[0], 0, 36'h0, 36'h0);
    pop(1'b1, 1'b0, 13'h0, 36'h0, 1, 36'h0, mem[0]);
    @(posedge clk);
    rom <= 1'b0;
    mem[0] = ~mem[0];
    pop(1'b0, 1'b1, 13'h0, mem[0], 0, 36'h0, 36'h0);
    pop(1'b1, 1'b0, 13'h0, 36'h0, 1, 36'h0, mem[0]);
    stop_test();
  end
endmodule : bmr_block_ram_tb_top

`default_nettype wire
